// [inc/pric_pkg.sv]
/*
 * package for the reset and interrupt control block: reset sequencing
 * constants, register reset values and the sequencer states.
 * assumes a single 40 MHz reference clock.
 */
package pric_pkg;
   // clock period in picoseconds
   localparam int unsigned PRIC_CLK_PERIOD_PS = 25000;
   // least hold of the global reset, in microseconds
   localparam int unsigned PRIC_GRST_MIN_US   = 2000;
   // least hold of the global reset in clock cycles, rounded up
   localparam int unsigned PRIC_GRST_MIN_CYC  =
      (PRIC_GRST_MIN_US * 1000000 + PRIC_CLK_PERIOD_PS - 1) / PRIC_CLK_PERIOD_PS;
   // stages of the reset release synchroniser
   localparam int unsigned PRIC_SYNC_STAGES   = 2;
   // reset value of the power-management context
   localparam logic [7:0]  PRIC_PM_CTX_RST    = 8'h00;
   // reset value of the vendor-specific bits
   localparam logic [7:0]  PRIC_VEND_RST      = 8'h00;
   // reset value of the general function register
   localparam logic [7:0]  PRIC_FUNC_RST      = 8'h00;

   // sequencer states
   typedef enum logic [1:0] {
      PRIC_ST_OFF,
      PRIC_ST_RUN
   } pric_state_t;
endpackage

// [inc/pric_rst_if.sv]
/*
 * interface carrying the synchronised reset levels from the reset
 * synchroniser to the control block.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pric_rst_if;
   logic g_run;   // global reset released and synchronised
   logic b_run;   // bus reset released and synchronised
   modport sync (output g_run, output b_run);
   modport ctrl (input g_run, input b_run);
endinterface

// [src/pric_rst_sync.sv]
/*
 * reset synchroniser: both resets assert at once, release after two
 * clock edges of ref_clk.
 * assumes ref_clk runs whenever a reset is released.
 */
`timescale 1ns/1ps
module pric_rst_sync
   import pric_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic g_rst_b,
   input  wire logic b_rst_b,
   pric_rst_if.sync  rst
);
   ////////////////////////////////////////////////////////////////////
   // global reset chain, cleared asynchronously
   logic [PRIC_SYNC_STAGES-1:0] g_sh_r;   // global release shift chain
   logic [PRIC_SYNC_STAGES-1:0] g_sh_nxt; // next chain value
   logic [PRIC_SYNC_STAGES-1:0] b_sh_r;   // bus release shift chain
   logic [PRIC_SYNC_STAGES-1:0] b_sh_nxt; // next chain value

   // shift in a one on each edge
   always_comb begin
      g_sh_nxt = {g_sh_r[PRIC_SYNC_STAGES-2:0], 1'b1};
      b_sh_nxt = {b_sh_r[PRIC_SYNC_STAGES-2:0], 1'b1};
   end

   // global chain register; asynchronous assert, synchronous release
   always_ff @(posedge ref_clk or negedge g_rst_b) begin
      if (!g_rst_b) begin
         g_sh_r <= '0;
      end else begin
         g_sh_r <= g_sh_nxt;
      end
   end

   // bus chain also drops on global reset
   always_ff @(posedge ref_clk or negedge b_rst_b or negedge g_rst_b) begin
      if (!b_rst_b || !g_rst_b) begin
         b_sh_r <= '0;
      end else begin
         b_sh_r <= b_sh_nxt;
      end
   end

   // only the last stage leaves the synchroniser
   assign rst.g_run = g_sh_r[PRIC_SYNC_STAGES-1];
   assign rst.b_run = b_sh_r[PRIC_SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////
   // assertions
   a_bus_under_global: assert property (@(posedge ref_clk)
      !rst.g_run |-> !rst.b_run)
      else $error("bus run high while global reset holds");
endmodule

// [src/pric_top.sv]
/*
 * reset and interrupt control of a serial-bus host controller on a
 * PCI or Mode_select_a host: two resets, output float, context retention,
 * one interrupt pin shared between PCI and Mode_select_a signalling.
 * assumes all inputs are synchronous to ref_clk except the resets.
 */
//
// Summary of operation
// - global reset restores every register default
// - global reset: idle, all outputs floating
// - bus reset: idle, all outputs floating
// - bus reset keeps power context, vendor bits
// - bus signals sampled on rising clock edge
// - one interrupt pin, Mode_select_a when select low
//
`timescale 1ns/1ps
module pric_top
   import pric_pkg::*;
#(
   parameter int unsigned FUNC_W = 8   // width of general function state
)
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic              bus_rst_b,
   input  wire logic              mode_select_a,
   input  wire logic              irq_event,
   input  wire logic              irq_clear,
   input  wire logic              pm_ctx_we,
   input  wire logic [7:0]        pm_ctx_wdata,
   input  wire logic              vend_we,
   input  wire logic [7:0]        vend_wdata,
   input  wire logic              func_we,
   input  wire logic [FUNC_W-1:0] func_wdata,
   output logic [7:0]             pm_ctx,
   output logic [7:0]             vend_bits,
   output logic [FUNC_W-1:0]      func_state,
   output logic                   dev_active,
   output logic                   host_interrupt_output_o,
   output logic                   host_interrupt_output_oe_b,
   output logic                   mode_select_a_mode
);
   ////////////////////////////////////////////////////////////////////
   // reset synchronisation
   pric_rst_if rst_i ();

   // release both resets on ref_clk
   pric_rst_sync u_sync (
      .ref_clk (ref_clk),
      .g_rst_b (rst_b),
      .b_rst_b (bus_rst_b),
      .rst     (rst_i.sync)
   );

   ////////////////////////////////////////////////////////////////////
   // retained state: only the global reset clears it
   logic [7:0] pm_ctx_r;    // power-management context
   logic [7:0] pm_ctx_nxt;  // next context
   logic [7:0] vend_r;      // vendor-specific bits
   logic [7:0] vend_nxt;    // next vendor bits
   logic       ret_wr_ok;   // both releases through the synchroniser

   // retained writes wait until both releases have crossed into ref_clk
   assign ret_wr_ok = rst_i.g_run & rst_i.b_run;

   // writes are taken only while both synchronised releases are high, from one cycle before the device runs
   always_comb begin
      pm_ctx_nxt = pm_ctx_r;
      vend_nxt   = vend_r;
      if (ret_wr_ok && pm_ctx_we) begin
         pm_ctx_nxt = pm_ctx_wdata;
      end
      if (ret_wr_ok && vend_we) begin
         vend_nxt = vend_wdata;
      end
   end

   // global reset restores the retained state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pm_ctx_r <= PRIC_PM_CTX_RST;
         vend_r   <= PRIC_VEND_RST;
      end else begin
         pm_ctx_r <= pm_ctx_nxt;
         vend_r   <= vend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // general state: cleared by either reset
   logic              rst_any_b;  // combined active-low reset
   pric_state_t       st_r;       // run state
   pric_state_t       st_nxt;     // next run state
   logic [FUNC_W-1:0] func_r;     // general function register
   logic [FUNC_W-1:0] func_nxt;   // next function value
   logic              irq_r;      // pending interrupt
   logic              irq_nxt;    // next pending interrupt

   // either reset asserts asynchronously
   assign rst_any_b = rst_b & bus_rst_b;

   // run only once the synchronised bus release arrives
   always_comb begin
      st_nxt   = st_r;
      func_nxt = func_r;
      irq_nxt  = irq_r;
      case (st_r)
         PRIC_ST_OFF: begin
            // hold here until the bus release has left the synchroniser
            if (rst_i.b_run) begin
               st_nxt = PRIC_ST_RUN;
            end
         end
         PRIC_ST_RUN: begin
            if (func_we) begin
               func_nxt = func_wdata;
            end
            // a new event wins over a clear in the same cycle
            if (irq_event) begin
               irq_nxt = 1'b1;
            end else if (irq_clear) begin
               irq_nxt = 1'b0;
            end
         end
         default: begin
            st_nxt = PRIC_ST_OFF;
         end
      endcase
   end

   // general state clears on either reset
   always_ff @(posedge ref_clk or negedge rst_any_b) begin
      if (!rst_any_b) begin
         st_r   <= PRIC_ST_OFF;
         func_r <= FUNC_W'(PRIC_FUNC_RST);
         irq_r  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         func_r <= func_nxt;
         irq_r  <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign pm_ctx     = pm_ctx_r;
   assign vend_bits  = vend_r;
   assign func_state = func_r;
   assign dev_active = (st_r == PRIC_ST_RUN);

   // interrupt pin: active low, driven only while running
   // the pin floats when nothing is pending, so the host pull-up holds it
   // high; it is never driven to the high level
   assign host_interrupt_output_o    = ~irq_r;
   assign host_interrupt_output_oe_b = ~(dev_active & irq_r);
   // the same pin carries the Mode_select_a interrupt when select is low
   assign mode_select_a_mode               = dev_active & ~mode_select_a;

   ////////////////////////////////////////////////////////////////////
   // assertions
   // all properties run on ref_clk; those that watch running behaviour
   // drop out while either reset holds
   a_glob_float: assert property (@(posedge ref_clk)
      !rst_b |-> host_interrupt_output_oe_b && !dev_active)
      else $error("output driven under global reset");

   a_bus_float: assert property (@(posedge ref_clk)
      !bus_rst_b |-> host_interrupt_output_oe_b && !dev_active)
      else $error("output driven under bus reset");

   a_glob_clear: assert property (@(posedge ref_clk)
      !rst_b |-> pm_ctx == PRIC_PM_CTX_RST && vend_bits == PRIC_VEND_RST)
      else $error("retained bits survive global reset");

   a_ctx_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(bus_rst_b) |=> $stable(pm_ctx) && $stable(vend_bits))
      else $error("bus reset disturbed retained bits");

   a_release_lag: assert property (@(posedge ref_clk)
      $rose(rst_any_b) |-> !dev_active ##1 !dev_active)
      else $error("device ran before synchronised release");

   a_run_within: assert property (@(posedge ref_clk) disable iff (!rst_any_b)
      $rose(rst_any_b) |-> ##[2:4] dev_active)
      else $error("device failed to start after release");

   a_irq_pin: assert property (@(posedge ref_clk) disable iff (!rst_any_b)
      irq_event && dev_active |=> !host_interrupt_output_oe_b && !host_interrupt_output_o)
      else $error("interrupt event not signalled");

   a_ctx_write: assert property (@(posedge ref_clk) disable iff (!rst_any_b)
      dev_active && pm_ctx_we |=> pm_ctx == $past(pm_ctx_wdata))
      else $error("context write not taken on edge");

   a_cb_mode: assert property (@(posedge ref_clk) disable iff (!rst_any_b)
      dev_active && !mode_select_a |-> mode_select_a_mode)
      else $error("mode_select_a mode missing while select low");

   // a write of the general register lands on the next edge
   a_func_write: assert property (@(posedge ref_clk) disable iff (!rst_any_b)
      dev_active && func_we |=> func_state == $past(func_wdata))
      else $error("function write not taken on edge");

   // a clear without an event releases the pin
   a_irq_release: assert property (@(posedge ref_clk) disable iff (!rst_any_b)
      dev_active && irq_clear && !irq_event |=> host_interrupt_output_oe_b)
      else $error("interrupt pin still driven after clear");

   // the bus reset clears the general state at once
   a_bus_clear: assert property (@(posedge ref_clk)
      !bus_rst_b |-> func_state == FUNC_W'(PRIC_FUNC_RST) && !dev_active)
      else $error("general state survives bus reset");

   // retained bits take no write before both releases are through
   a_ret_refused: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !ret_wr_ok |=> $stable(pm_ctx) && $stable(vend_bits))
      else $error("retained bits written before release");

   // running implies both releases have been synchronised
   a_run_synced: assert property (@(posedge ref_clk)
      dev_active |-> rst_i.g_run && rst_i.b_run)
      else $error("device runs ahead of the synchroniser");
endmodule

// [verification/pric_host_model.sv]
/* host side model: one power-up global reset, bus reset from the host line,
   pull-up on the interrupt wire. assumes ref_clk runs from time zero. */
`timescale 1ns/1ps
module pric_host_model
   import pric_pkg::*;
#(
   parameter int unsigned HOLD = PRIC_GRST_MIN_CYC  // least global reset hold
)
(
   input  wire logic ref_clk,
   input  wire logic g_req,     // ask for another global reset
   input  wire logic host_rst,  // host bus reset line, high = reset
   input  wire logic int_o,     // pin value from the device
   input  wire logic int_oe_b,  // pin enable, low = driven
   output logic      rst_b,
   output logic      bus_rst_b,
   output logic      int_line   // resolved interrupt wire
);
   int unsigned cnt_r = 0;  // cycles of global reset held so far
   // count the hold; every request restarts it
   always @(posedge ref_clk or posedge g_req) begin
      if (g_req) cnt_r <= 0;
      else if (cnt_r < HOLD) cnt_r <= cnt_r + 1;
   end
   assign rst_b     = (cnt_r >= HOLD) && !g_req;
   assign bus_rst_b = !host_rst;
   assign int_line  = int_oe_b ? 1'b1 : int_o;    // pull-up when floating
endmodule

// [verification/tb_pci_reset_interrupt_control.sv]
/* bench for the reset and interrupt control: table of writes and
   interrupt steps, then bus and global reset cases.
   assumes the host model makes both resets. */
`timescale 1ns/1ps
module tb_pci_reset_interrupt_control
   import pric_pkg::*;
;
   typedef struct packed {
      logic ev; logic clr; logic mode; logic [7:0] d; logic ex_int; logic ex_cb;
   } pric_row_t;
   logic ref_clk = 0, rst_b, bus_rst_b, g_req = 0, host_rst = 0;
   logic mode_select_a = 1, irq_event = 0, irq_clear = 0;
   logic pm_ctx_we = 0, vend_we = 0, func_we = 0;
   logic [7:0] wd = 8'h00, pm_ctx, vend_bits, func_state;
   logic dev_active, int_o, int_oe_b, mode_select_a_mode, int_line;
   int fail_count = 0, checks_done = 0;
   pric_row_t rows [5] = '{
      '{1'b0, 1'b0, 1'b1, 8'hA5, 1'b1, 1'b0}, '{1'b1, 1'b0, 1'b0, 8'h3C, 1'b0, 1'b1},
      '{1'b0, 1'b0, 1'b0, 8'hFF, 1'b0, 1'b1}, '{1'b1, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0},
      '{1'b0, 1'b1, 1'b1, 8'h5A, 1'b1, 1'b0}};
   // 25 ns clock
   always #12.5 ref_clk = ~ref_clk;
   pric_host_model #(.HOLD(2)) u_pric_host_model (.ref_clk(ref_clk), .g_req(g_req),
      .host_rst(host_rst), .int_o(int_o), .int_oe_b(int_oe_b), .rst_b(rst_b),
      .bus_rst_b(bus_rst_b), .int_line(int_line));
   pric_top u_pric_top (.ref_clk(ref_clk), .rst_b(rst_b), .bus_rst_b(bus_rst_b),
      .mode_select_a(mode_select_a), .irq_event(irq_event), .irq_clear(irq_clear),
      .pm_ctx_we(pm_ctx_we), .pm_ctx_wdata(wd), .vend_we(vend_we), .vend_wdata(wd),
      .func_we(func_we), .func_wdata(wd), .pm_ctx(pm_ctx), .vend_bits(vend_bits),
      .func_state(func_state), .dev_active(dev_active), .host_interrupt_output_o(int_o),
      .host_interrupt_output_oe_b(int_oe_b), .mode_select_a_mode(mode_select_a_mode));
   ////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // verdict
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      wait (dev_active === 1'b1);
      foreach (rows[i]) begin
         @(posedge ref_clk);
         {irq_event, irq_clear, mode_select_a, wd} <= {rows[i].ev, rows[i].clr, rows[i].mode, rows[i].d};
         {pm_ctx_we, vend_we, func_we} <= 3'b111;
         @(posedge ref_clk);
         {pm_ctx_we, vend_we, func_we, irq_event, irq_clear} <= 5'b0;
         #1;
         chk("func", func_state, rows[i].d);
         chk("pm", pm_ctx, rows[i].d);
         chk("vend", vend_bits, rows[i].d);
         chk("int", int_line, rows[i].ex_int);
         chk("cb", mode_select_a_mode, rows[i].ex_cb);
      end
      // bus reset with a pending interrupt and fresh writes just before it
      @(posedge ref_clk);
      {irq_event, pm_ctx_we, func_we, wd} <= {3'b111, 8'h77};
      @(posedge ref_clk);
      host_rst <= 1'b1;
      wd       <= 8'h11;
      #1;
      chk("oe", int_oe_b, 1'b1);
      chk("act", dev_active, 1'b0);
      chk("func", func_state, PRIC_FUNC_RST);
      chk("pm", pm_ctx, 8'h77);
      chk("vend", vend_bits, 8'h5A);
      // the writes still offered at this edge fall inside the bus reset
      @(posedge ref_clk);
      {irq_event, host_rst, func_we, pm_ctx_we} <= 4'b0000;
      repeat (2) @(posedge ref_clk);
      #1 chk("act", dev_active, 1'b0);
      @(posedge ref_clk);
      #1 chk("act", dev_active, 1'b1);
      chk("func", func_state, PRIC_FUNC_RST);
      chk("int", int_line, 1'b1);
      chk("pm", pm_ctx, 8'h77);
      // global reset clears the kept context too
      g_req <= 1'b1;
      #1 chk("oe", int_oe_b, 1'b1);
      chk("pm", pm_ctx, PRIC_PM_CTX_RST);
      chk("vend", vend_bits, PRIC_VEND_RST);
      @(posedge ref_clk);
      g_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 chk("act", dev_active, 1'b0);
      @(posedge ref_clk);
      #1 chk("act", dev_active, 1'b1);
      end_of_test();
   end
   // watchdog
   initial begin
      #50000;
      fail_count++;
      end_of_test();
   end
endmodule
